// *** design/prog_seq_pkg.sv ***
// Purpose: Constants shared by the flash self-program sequencer.
// Assumes: 25 MHz system clock.
// Notes: Control register layout follows the command codes given to software.
package prog_seq_pkg;
  // Control register field positions
  localparam int BIT_OP_EN = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_LOCK = 3;
  localparam int BIT_REEN = 4;
  localparam int BIT_BUSY = 6;
  localparam int BIT_IRQ_EN = 7;
  // Command codes in the low five bits
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_REEN = 5'h11;
  // Register offsets on the local port
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_LOCKS = 3'h1;
  localparam logic [2:0] OFS_PAGE = 3'h2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [5:0] LOCKS_RESET = 6'h3F;
  // Store must follow the command within this many cycles
  localparam int STORE_WINDOW = 4;
  // Programming time, microseconds, and clock rate
  localparam int PROG_MIN_US = 3700;
  localparam int CLK_MHZ = 25;
  localparam int PROG_CYCLES = PROG_MIN_US * CLK_MHZ;
endpackage : prog_seq_pkg

// *** design/flash_self_program_sequencer.sv ***
// Purpose: Self-program sequencer: page buffer, page erase/write, lock-set.
// Assumes: Core strobes a store on the same clock; flash array lies outside.
// Notes: Busy time uses the minimum programming time of the flash.
// Behaviour
// - Erase runs only on erase code then store within four cycles.
// - Erase takes page from page field; data and other bits ignored.
// - Erase of read-while-write section leaves other readable; else halts core.
// - Buffer load writes data word at pointer bits 5..1 on load code plus store.
// - Buffer cleared after page write, on reenable write, and on reset.
// - An EEPROM write during loading discards all loaded words.
// - Page write needs write code plus store within four cycles; data ignored.
// - Write to read-while-write section leaves other readable; else halts core.
// - Enabled interrupt is a level while operation-enable bit is clear.
// - Buffer words may be loaded in any order.
// - Reads of read-while-write section blocked during erase or write.
// - Section-busy bit set while the read-while-write section is busy.
// - Lock-set uses data low register value, lock code, store within four.
// - Each zero among data bits 5..0 programs that lock bit.
// - Whole flash stays readable while lock bits program.
// - EEPROM write busy refuses every programming command.
// - Command bits self-clear when no store follows within four cycles.
// - Erase, write or lock-set lasts PROG_TIME cycles, 3.7 ms at 25 MHz.
`timescale 1ns/1ns
`default_nettype none
module flash_self_program_sequencer #(
  parameter int PAGE_BITS = 8,
  parameter int WORDS = 32,
  parameter int PROG_TIME = prog_seq_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core store instruction and its operands
  input wire logic store_instr,
  input wire logic [15:0] addr_pointer,
  input wire logic [7:0] data_low_register,
  input wire logic [7:0] data_high_register,
  // EEPROM write busy, from same clock domain
  input wire logic eeprom_write_busy_bit,
  // Flash array side
  input wire logic target_in_rww,
  output logic core_halt,
  output logic rww_read_block,
  output logic flash_erase,
  output logic flash_write,
  output logic [PAGE_BITS-1:0] flash_page,
  output logic [5:0] lock_bits,
  output logic irq
);
  localparam int WB = $clog2(WORDS);
  typedef enum logic [1:0] {IDLE, ERASE, WRITE, LOCK} op_t;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] win;
    op_t op;
    logic [31:0] timer;
    logic [WORDS-1:0] loaded;
    logic loading;
    logic [PAGE_BITS-1:0] page;
    logic [5:0] locks;
    logic halt;
    logic rww_blk;
    logic pulse_e;
    logic pulse_w;
    logic irq;
    logic [7:0] rdata;
  } state_t;
  state_t s, next_s;
  logic [15:0] buffer [WORDS];
  logic do_load;
  logic [WB-1:0] load_idx;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [4:0] cmd;
    logic take;
    next_s = s;
    cmd = s.ctrl[4:0];
    take = store_instr && s.ctrl[prog_seq_pkg::BIT_OP_EN] && s.win != 3'h0 && s.op == IDLE
      && !eeprom_write_busy_bit;
    do_load = 1'b0;
    load_idx = addr_pointer[WB:1];
    next_s.pulse_e = 1'b0;
    next_s.pulse_w = 1'b0;
    next_s.rdata = 8'h00;
    // Window countdown; unused enable bits self-clear
    // A store in the last window cycle wins, or the running command would lose its code
    if (s.win != 3'h0) begin
      next_s.win = s.win - 3'h1;
      if (s.win == 3'h1 && s.op == IDLE && !take) begin
        next_s.ctrl[4:0] = 5'h00;
      end
    end
    // EEPROM write mid-load discards the buffer
    if (eeprom_write_busy_bit && s.loading) begin
      next_s.loaded = '0;
      next_s.loading = 1'b0;
    end
    if (take) begin
      next_s.win = 3'h0;
      // Only the first load of a word lands until the buffer is flushed
      if (cmd == prog_seq_pkg::CMD_LOAD) begin
        do_load = !s.loaded[load_idx];
        next_s.loaded[load_idx] = 1'b1;
        next_s.loading = 1'b1;
        next_s.ctrl[4:0] = 5'h00;
      end else if (cmd == prog_seq_pkg::CMD_ERASE || cmd == prog_seq_pkg::CMD_WRITE) begin
        next_s.op = (cmd == prog_seq_pkg::CMD_ERASE) ? ERASE : WRITE;
        next_s.page = addr_pointer[WB+1 +: PAGE_BITS];
        next_s.pulse_e = (cmd == prog_seq_pkg::CMD_ERASE);
        next_s.pulse_w = (cmd == prog_seq_pkg::CMD_WRITE);
        next_s.timer = PROG_TIME - 1;
        // Halt the core only when the target is outside the read-while-write section
        next_s.halt = !target_in_rww;
        next_s.rww_blk = 1'b1;
        next_s.ctrl[prog_seq_pkg::BIT_BUSY] = 1'b1;
      // Lock bits only move towards programmed; a one in the data keeps the old value
      end else if (cmd == prog_seq_pkg::CMD_LOCK) begin
        next_s.op = LOCK;
        next_s.locks = s.locks & data_low_register[5:0];
        next_s.timer = PROG_TIME - 1;
      // Reenable also flushes the buffer, so a pre-filled buffer is lost here
      end else if (cmd == prog_seq_pkg::CMD_REEN) begin
        next_s.loaded = '0;
        next_s.loading = 1'b0;
        next_s.ctrl[prog_seq_pkg::BIT_BUSY] = 1'b0;
        next_s.rww_blk = 1'b0;
        next_s.ctrl[4:0] = 5'h00;
      end
    end
    // Operation timer and completion
    case (s.op)
      IDLE: ;
      default: begin
        if (s.timer == 32'h0) begin
          next_s.op = IDLE;
          next_s.ctrl[4:0] = 5'h00;
          // Busy and the read block stay set until software reenables the section
          next_s.halt = 1'b0;
          if (s.op == WRITE) begin
            next_s.loaded = '0;
            next_s.loading = 1'b0;
          end
        end else begin
          next_s.timer = s.timer - 32'h1;
        end
      end
    endcase
    // Register writes; refused while an operation runs
    // Irq enable stays writable while the EEPROM is busy; only commands are held off
    if (reg_wr && reg_addr == prog_seq_pkg::OFS_CTRL && s.op == IDLE) begin
      next_s.ctrl[prog_seq_pkg::BIT_IRQ_EN] = reg_wdata[prog_seq_pkg::BIT_IRQ_EN];
      if (!eeprom_write_busy_bit) begin
        next_s.ctrl[4:0] = reg_wdata[4:0];
        next_s.win = (reg_wdata[prog_seq_pkg::BIT_OP_EN]) ? 3'(prog_seq_pkg::STORE_WINDOW) : 3'h0;
      end
    end
    // Register reads
    // Read data stand for one cycle only and are zero otherwise
    if (reg_rd) begin
      if (reg_addr == prog_seq_pkg::OFS_CTRL) begin
        next_s.rdata = s.ctrl;
      end else if (reg_addr == prog_seq_pkg::OFS_LOCKS) begin
        next_s.rdata = {2'b11, s.locks};
      end else if (reg_addr == prog_seq_pkg::OFS_PAGE) begin
        next_s.rdata = 8'(s.page);
      end else begin
        next_s.rdata = 8'h00;
      end
    end
    next_s.irq = s.ctrl[prog_seq_pkg::BIT_IRQ_EN] && !next_s.ctrl[prog_seq_pkg::BIT_OP_EN];
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; buffer words kept in plain storage
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.ctrl <= prog_seq_pkg::CTRL_RESET;
      s.locks <= prog_seq_pkg::LOCKS_RESET;
      s.op <= IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Buffer data needs no reset: the valid mask is cleared instead
  always_ff @(posedge mclk) begin
    if (do_load) begin
      buffer[load_idx] <= {data_high_register, data_low_register};
    end
  end

  assign reg_rdata = s.rdata;
  assign core_halt = s.halt;
  assign rww_read_block = s.rww_blk;
  assign flash_erase = s.pulse_e;
  assign flash_write = s.pulse_w;
  assign flash_page = s.page;
  assign lock_bits = s.locks;
  assign irq = s.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Each kind of accepted store is named once; eight of the properties are built on these
  sequence erase_taken;
    store_instr && s.win != 3'h0 && s.op == IDLE && !eeprom_write_busy_bit
      && s.ctrl[4:0] == prog_seq_pkg::CMD_ERASE;
  endsequence
  sequence write_taken;
    store_instr && s.win != 3'h0 && s.op == IDLE && !eeprom_write_busy_bit
      && s.ctrl[4:0] == prog_seq_pkg::CMD_WRITE;
  endsequence
  sequence load_taken;
    store_instr && s.win != 3'h0 && s.op == IDLE && !eeprom_write_busy_bit
      && s.ctrl[4:0] == prog_seq_pkg::CMD_LOAD;
  endsequence
  sequence lock_taken;
    store_instr && s.win != 3'h0 && s.op == IDLE && !eeprom_write_busy_bit
      && s.ctrl[4:0] == prog_seq_pkg::CMD_LOCK;
  endsequence
  sequence reen_taken;
    store_instr && s.win != 3'h0 && s.op == IDLE && !eeprom_write_busy_bit
      && s.ctrl[4:0] == prog_seq_pkg::CMD_REEN;
  endsequence
  a_erase_start: assert property (@(posedge mclk) disable iff (sys_rst)
    erase_taken |=> s.op == ERASE && flash_erase && rww_read_block)
    else $error("erase not started");
  a_eeprom_refuse: assert property (@(posedge mclk) disable iff (sys_rst)
    eeprom_write_busy_bit && s.op == IDLE |=> !flash_erase && !flash_write)
    else $error("command taken during eeprom write");
  a_busy_held: assert property (@(posedge mclk) disable iff (sys_rst)
    s.op == ERASE || s.op == WRITE |-> s.ctrl[prog_seq_pkg::BIT_BUSY])
    else $error("busy bit low during operation");
  a_window_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    s.win == 3'h1 && s.op == IDLE && !store_instr && !reg_wr |=> s.ctrl[4:0] == 5'h00)
    else $error("command bits not cleared");
  a_done_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    s.op != IDLE && s.timer == 32'h0 |=> s.op == IDLE && !s.ctrl[prog_seq_pkg::BIT_OP_EN])
    else $error("operation end did not clear enable");
  a_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
    irq == ($past(s.ctrl[prog_seq_pkg::BIT_IRQ_EN]) && !s.ctrl[prog_seq_pkg::BIT_OP_EN]))
    else $error("irq level does not follow enable bits");
  a_write_flush: assert property (@(posedge mclk) disable iff (sys_rst)
    s.op == WRITE && s.timer == 32'h0 |=> s.loaded == '0)
    else $error("buffer not flushed after write");
  a_lock_readable: assert property (@(posedge mclk) disable iff (sys_rst)
    s.op == LOCK |-> !core_halt)
    else $error("core halted during lock set");
  a_lock_program: assert property (@(posedge mclk) disable iff (sys_rst)
    lock_taken |=> lock_bits == ($past(lock_bits) & $past(data_low_register[5:0])))
    else $error("lock bits wrong");
  // Command bits stay up while an operation runs, so the interrupt cannot fire early
  a_enable_held: assert property (@(posedge mclk) disable iff (sys_rst)
    s.op != IDLE |-> s.ctrl[prog_seq_pkg::BIT_OP_EN])
    else $error("operation enable low during operation");
  // Page write start mirrors the erase start
  a_write_start: assert property (@(posedge mclk) disable iff (sys_rst)
    write_taken |=> s.op == WRITE && flash_write && rww_read_block)
    else $error("write not started");
  a_strobe_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    flash_erase || flash_write |=> !flash_erase && !flash_write)
    else $error("start strobe longer than one cycle");
  a_page_latch: assert property (@(posedge mclk) disable iff (sys_rst)
    erase_taken |=> flash_page == $past(addr_pointer[WB+1 +: PAGE_BITS]))
    else $error("page not taken from page field");
  // Halt only when the target lies outside the read-while-write section
  a_erase_halt: assert property (@(posedge mclk) disable iff (sys_rst)
    erase_taken |=> core_halt == !$past(target_in_rww))
    else $error("halt wrong for erase");
  a_write_halt: assert property (@(posedge mclk) disable iff (sys_rst)
    write_taken |=> core_halt == !$past(target_in_rww))
    else $error("halt wrong for write");
  a_block_held: assert property (@(posedge mclk) disable iff (sys_rst)
    s.op == ERASE || s.op == WRITE |-> rww_read_block)
    else $error("section readable during operation");
  // Buffer words: the first load lands, repeats are dropped, EEPROM writes discard
  a_load_store: assert property (@(posedge mclk) disable iff (sys_rst)
    do_load |=> buffer[$past(load_idx)] == $past({data_high_register, data_low_register}))
    else $error("buffer word not loaded");
  a_load_once: assert property (@(posedge mclk) disable iff (sys_rst)
    load_taken ##0 s.loaded[load_idx] |=> buffer[$past(load_idx)] == $past(buffer[load_idx]))
    else $error("repeated load changed a word");
  a_load_discard: assert property (@(posedge mclk) disable iff (sys_rst)
    eeprom_write_busy_bit && s.loading |=> s.loaded == '0)
    else $error("loads kept across eeprom write");
  a_reen_flush: assert property (@(posedge mclk) disable iff (sys_rst)
    reen_taken |=> s.loaded == '0 && !s.ctrl[prog_seq_pkg::BIT_BUSY] && !rww_read_block)
    else $error("reenable did not flush and release");
endmodule : flash_self_program_sequencer
`default_nettype wire

// *** testbench/core_side.sv ***
// Purpose: Core model: register writes and reads, then a store.
// Assumes: One clock; strobes last one cycle.
// Notes: Pointer and data low flip after a store so stale values are never trusted.
`timescale 1ns/1ns
`default_nettype none
module core_side (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [2:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Store and operands
  output logic store_instr,
  output logic [15:0] addr_pointer,
  output logic [7:0] data_low_register,
  output logic [7:0] data_high_register
);
  // Idle lines at time zero
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    store_instr = 1'b0;
    addr_pointer = 16'h0000;
    data_low_register = 8'h00;
    data_high_register = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read strobe; data stand only in the following cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Command write, then a store gap cycles later
  task automatic spm(input logic [7:0] ctl, input logic [15:0] ptr, input logic [7:0] dlo, input int gap);
    // Let the previous call's operand flip land before new operands go out
    @(posedge mclk);
    addr_pointer <= ptr;
    data_low_register <= dlo;
    data_high_register <= ~dlo;
    wr(prog_seq_pkg::OFS_CTRL, ctl);
    repeat (gap - 1) @(posedge mclk);
    store_instr <= 1'b1;
    @(posedge mclk);
    store_instr <= 1'b0;
    addr_pointer <= ~ptr;
    data_low_register <= ~dlo;
  endtask : spm
endmodule : core_side
`default_nettype wire

// *** testbench/flash_self_program_sequencer_tb.sv ***
// Purpose: Self-checking bench of the self-program sequencer.
// Assumes: Short programming time so a run stays brief.
// Notes: Buffer contents have no port, so only control effects are seen.
`timescale 1ns/1ns
`default_nettype none
module flash_self_program_sequencer_tb;
  localparam int PT = 20;
  logic mclk, sys_rst, store_instr, reg_wr, reg_rd, eeb, read_while_write_section, core_halt, rblk, fe, fw, irq;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, dlo, dhi, flash_page, v;
  logic [15:0] ptr;
  logic [5:0] lock_bits;
  int n_mismatch, n_compared, n_erase, n_write, cycles, t0;
  core_side core (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .store_instr(store_instr), .addr_pointer(ptr), .data_low_register(dlo),
    .data_high_register(dhi));
  flash_self_program_sequencer #(.PROG_TIME(PT)) uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_instr(store_instr),
    .addr_pointer(ptr), .data_low_register(dlo), .data_high_register(dhi), .eeprom_write_busy_bit(eeb),
    .target_in_rww(read_while_write_section), .core_halt(core_halt), .rww_read_block(rblk), .flash_erase(fe), .flash_write(fw),
    .flash_page(flash_page), .lock_bits(lock_bits), .irq(irq));
  // Clock, 40 ns period
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
    core.rd(a, v);
    chk(what, exp, v);
  endtask : rchk
  // Poll until done, bounded; optionally check the duration
  task automatic wait_idle(input bit timed);
    int i;
    i = 0;
    v = 8'hFF;
    while (v[0] !== 1'b0 && i < 60) begin
      core.rd(prog_seq_pkg::OFS_CTRL, v);
      i++;
    end
    chk("op end", 8'h00, {7'h0, v[0]});
    if (timed) chk("prog time", 8'h01, {7'h0, (cycles - t0) >= PT - 2 && (cycles - t0) < PT + 8});
  endtask : wait_idle
  // Strobe counters and hang limit; a long stall means a dead handshake
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (fe === 1'b1) n_erase <= n_erase + 1;
    if (fw === 1'b1) n_write <= n_write + 1;
    if (fe === 1'b1 || fw === 1'b1) t0 <= cycles;
    if (cycles == 4000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    eeb = 1'b0;
    read_while_write_section = 1'b1;
    {n_mismatch, n_compared, n_erase, n_write, cycles, t0} = '0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk("ctrl reset", prog_seq_pkg::OFS_CTRL, prog_seq_pkg::CTRL_RESET);
    rchk("locks reset", prog_seq_pkg::OFS_LOCKS, {2'b11, prog_seq_pkg::LOCKS_RESET});
    rchk("unmapped", 3'h5, 8'h00);
    $display("reset test done");
    core.spm(8'h03, 16'hD6BF, 8'h00, 5);
    core.spm(8'h01, 16'h0004, 8'h3C, 2);
    repeat (4) @(posedge mclk);
    rchk("ctrl cleared", prog_seq_pkg::OFS_CTRL, 8'h00);
    chk("no strobes", 8'h00, 8'(n_erase + n_write));
    $display("window test done");
    core.spm(8'h83, 16'hD6BF, 8'h77, 4);
    repeat (2) @(posedge mclk);
    #1 chk("erase strobe", 8'h01, 8'(n_erase));
    chk("page", 8'h5A, flash_page);
    chk("halt rww", 8'h01, {6'h0, core_halt, rblk});
    chk("irq running", 8'h00, {7'h0, irq});
    rchk("ctrl running", prog_seq_pkg::OFS_CTRL, 8'hC3);
    wait_idle(1'b1);
    rchk("ctrl done", prog_seq_pkg::OFS_CTRL, 8'hC0);
    chk("irq done", 8'h01, {7'h0, irq});
    core.spm(8'h11, 16'h0000, 8'h00, 1);
    wait_idle(1'b0);
    rchk("busy cleared", prog_seq_pkg::OFS_CTRL, 8'h00);
    chk("block cleared", 8'h00, {7'h0, rblk});
    $display("erase test done");
    read_while_write_section <= 1'b0;
    core.spm(8'h05, 16'h1680, 8'h99, 3);
    repeat (2) @(posedge mclk);
    #1 chk("write strobe", 8'h01, 8'(n_write));
    chk("halt no_read_while_write_section", 8'h01, {7'h0, core_halt});
    rchk("page reg", prog_seq_pkg::OFS_PAGE, 8'h5A);
    wait_idle(1'b1);
    chk("halt released", 8'h00, {7'h0, core_halt});
    core.spm(8'h11, 16'h0000, 8'h00, 1);
    wait_idle(1'b0);
    $display("write test done");
    core.spm(8'h09, 16'h0001, 8'hE5, 2);
    repeat (2) @(posedge mclk);
    #1 chk("lock readable", 8'h00, {6'h0, core_halt, rblk});
    wait_idle(1'b0);
    chk("lock pins", 8'h25, {2'b00, lock_bits});
    rchk("lock reg", prog_seq_pkg::OFS_LOCKS, 8'hE5);
    $display("lock test done");
    core.spm(8'h01, 16'h000A, 8'h12, 2);
    core.spm(8'h01, 16'h000A, 8'h34, 3);
    rchk("load ctrl", prog_seq_pkg::OFS_CTRL, 8'h00);
    eeb <= 1'b1;
    core.spm(8'h05, 16'h2940, 8'h00, 1);
    repeat (4) @(posedge mclk);
    rchk("refused ctrl", prog_seq_pkg::OFS_CTRL, 8'h00);
    chk("refused write", 8'h01, 8'(n_write));
    eeb <= 1'b0;
    $display("eeprom test done");
    give_verdict();
  end
endmodule : flash_self_program_sequencer_tb
`default_nettype wire
